/* File: hw/charger_powerup_switch_sequencer.sv */
// Behaviour
// RQ1 - supply rise resets all register fields
// RQ2 - battery only: switch closed, regulator off
// RQ3 - switch-off request opens switch after delay
// RQ4 - host sets switch-off request without battery
// RQ5 - host disables watchdog with switch-off request; no watchdog disable here, watchdog_expired_i still clears the request
// RQ6 - insertion, write zero, watchdog, reset clear request
// RQ7 - held wake press closes switch, ends shipping
// RQ8 - long wake press pulses switch open
// RQ9 - long-press reset gated by enable bit
// RQ10 - regulator needs supply, sleep condition, delay
// RQ11 - otherwise high impedance, battery feeds system
// RQ12 - qualify input under test load first
// RQ13 - pass sets power good, pin, interrupt
// RQ14 - failed qualification retried every interval
// RQ15 - limit detection runs after power good
// RQ16 - detection writes status and limit fields
// RQ17 - select high: second pin picks limit
// RQ18 - host high impedance holds until cleared
// RQ19 - interval counters restart on dropped condition
`timescale 1ns/10ps
`include "seq_map.svh"
module charger_powerup_switch_sequencer
    import seq_pkg::*;
#(
    parameter logic [31:0] SW_OFF_DLY_CYC =
        32'(`SEQ_MS_TO_CYC(`SEQ_SW_OFF_DLY_MS)),
    parameter logic [31:0] WAKE_ON_CYC    =
        32'(`SEQ_MS_TO_CYC(`SEQ_WAKE_ON_MS)),
    parameter logic [31:0] LONG_PRESS_CYC =
        32'(`SEQ_MS_TO_CYC(`SEQ_LONG_PRESS_MS)),
    parameter logic [31:0] SW_RST_CYC     =
        32'(`SEQ_MS_TO_CYC(`SEQ_SW_RST_MS)),
    parameter logic [31:0] REG_DLY_CYC    =
        32'(`SEQ_MS_TO_CYC(`SEQ_REG_DLY_MS)),
    parameter logic [31:0] POOR_TEST_CYC  =
        32'(`SEQ_MS_TO_CYC(`SEQ_POOR_TEST_MS)),
    parameter logic [31:0] RETRY_CYC      =
        32'(`SEQ_MS_TO_CYC(`SEQ_RETRY_MS))
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       vbus_above_uvlo_i,
    input  wire logic       bat_above_uvlo_i,
    input  wire logic       bat_above_depl_i,
    input  wire logic       sleep_ok_i,
    input  wire logic       input_ovp_i,
    input  wire logic       input_above_poor_i,
    input  wire logic       wake_pin_n_i,
    input  wire logic       source_select_i,
    input  wire logic       second_limit_pin_i,
    input  wire logic       switch_off_wr_i,
    input  wire logic       switch_off_wdata_i,
    input  wire logic       watchdog_expired_i,
    input  wire logic       register_reset_i,
    input  wire logic       system_reset_enable_i,
    input  wire logic       host_high_imp_i,
    input  wire logic       limit_wr_i,
    input  wire logic [2:0] limit_wdata_i,
    output logic            battery_switch_on_o,
    output logic            internal_regulator_en_o,
    output logic            high_impedance_state_o,
    output logic            poor_test_load_o,
    output logic            buck_enable_o,
    output logic            power_good_o,
    output logic            power_good_pin_n_o,
    output logic            int_o,
    output logic            switch_off_request_o,
    output logic [1:0]      source_status_field_o,
    output logic [2:0]      input_limit_field_o
);
    qual_state_type state;
    qual_state_type next_state;
    logic           supply_ok_q;
    logic           vbus_q;
    logic           soft_rst;
    logic           vbus_rise;
    logic           wake_armed;
    logic           wake_on_q;
    logic           wake_on_evt;
    logic           rst_pulse;
    logic           reg_cond;

    tmr_if off_t ();
    tmr_if wake_t ();
    tmr_if long_t ();
    tmr_if pulse_t ();
    tmr_if reg_t ();
    tmr_if test_t ();
    tmr_if retry_t ();

    // Interval timers, one per delay
    interval_timer #(.LIMIT(SW_OFF_DLY_CYC)) u_off (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(off_t));
    interval_timer #(.LIMIT(WAKE_ON_CYC)) u_wake (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(wake_t));
    interval_timer #(.LIMIT(LONG_PRESS_CYC)) u_long (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(long_t));
    interval_timer #(.LIMIT(SW_RST_CYC)) u_pulse (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(pulse_t));
    interval_timer #(.LIMIT(REG_DLY_CYC)) u_reg (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(reg_t));
    interval_timer #(.LIMIT(POOR_TEST_CYC)) u_test (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(test_t));
    interval_timer #(.LIMIT(RETRY_CYC)) u_retry (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .t(retry_t));

    // Supply and input edge tracking
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            supply_ok_q <= 1'b0;
            vbus_q      <= 1'b0;
            wake_on_q   <= 1'b0;
        end else begin
            supply_ok_q <= vbus_above_uvlo_i | bat_above_uvlo_i;
            vbus_q      <= vbus_above_uvlo_i;
            wake_on_q   <= wake_t.done;
        end
    end

    // Register reset on supply rise or host reset bit
    assign soft_rst  = ((vbus_above_uvlo_i | bat_above_uvlo_i)
                        & ~supply_ok_q) | register_reset_i; // RQ1
    assign vbus_rise = vbus_above_uvlo_i & ~vbus_q;

    // Switch-off request: host set wins over any clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            switch_off_request_o <= 1'b0;
        end else if (switch_off_wr_i && switch_off_wdata_i) begin
            switch_off_request_o <= 1'b1; // RQ3
        end else if (soft_rst || vbus_rise || switch_off_wr_i
                     || watchdog_expired_i || wake_on_evt) begin
            switch_off_request_o <= 1'b0; // RQ6 RQ7
        end
    end

    // Forced-off delay runs while the request stands
    assign off_t.run = switch_off_request_o; // RQ3 RQ19

    // Wake press needs a high level first, then a held low
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_armed <= 1'b0;
        end else if (wake_pin_n_i) begin
            wake_armed <= 1'b1;
        end else if (long_t.done) begin
            wake_armed <= 1'b0;
        end
    end

    assign wake_t.run  = wake_armed & ~wake_pin_n_i; // RQ7 RQ19
    assign wake_on_evt = wake_t.done & ~wake_on_q; // RQ7
    assign long_t.run  = wake_armed & ~wake_pin_n_i & ~vbus_above_uvlo_i
                         & ~switch_off_request_o
                         & system_reset_enable_i; // RQ8 RQ9

    // Switch reset pulse after a long press
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pulse <= 1'b0;
        end else if (long_t.done) begin
            rst_pulse <= 1'b1; // RQ8
        end else if (pulse_t.done) begin
            rst_pulse <= 1'b0;
        end
    end

    assign pulse_t.run = rst_pulse;

    // Battery switch drive
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            battery_switch_on_o <= 1'b0;
        end else begin
            battery_switch_on_o <= bat_above_depl_i & ~off_t.done
                                   & ~rst_pulse; // RQ2 RQ3 RQ8
        end
    end

    // Regulator enable conditions and start-up delay
    assign reg_cond  = vbus_above_uvlo_i & sleep_ok_i & ~host_high_imp_i;
    assign reg_t.run = reg_cond; // RQ10 RQ19

    // Qualification sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (reg_t.done) begin
                    next_state = ST_QUALIFY; // RQ10
                end
            end
            ST_QUALIFY: begin
                if (input_ovp_i || !input_above_poor_i) begin
                    next_state = ST_RETRY; // RQ12
                end else if (test_t.done) begin
                    next_state = ST_DETECT; // RQ13
                end
            end
            ST_RETRY: begin
                if (retry_t.done) begin
                    next_state = ST_QUALIFY; // RQ14
                end
            end
            ST_DETECT: next_state = ST_READY; // RQ15
            ST_READY:  next_state = ST_READY;
            default:   next_state = ST_IDLE;
        endcase
        if (!reg_cond) begin
            next_state = ST_IDLE; // RQ11 RQ18
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign test_t.run  = (state == ST_QUALIFY) && reg_cond; // RQ12
    assign retry_t.run = (state == ST_RETRY) && reg_cond; // RQ14

    // Converter side outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            internal_regulator_en_o <= 1'b0;
            high_impedance_state_o  <= 1'b1;
            poor_test_load_o        <= 1'b0;
            buck_enable_o           <= 1'b0;
        end else begin
            internal_regulator_en_o <= next_state != ST_IDLE; // RQ10
            high_impedance_state_o  <= next_state == ST_IDLE; // RQ11
            poor_test_load_o        <= next_state == ST_QUALIFY;
            buck_enable_o           <= next_state == ST_READY;
        end
    end

    // Power good status, pin and interrupt
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_good_o       <= 1'b0;
            power_good_pin_n_o <= 1'b1;
            int_o              <= 1'b0;
        end else begin
            power_good_o       <= next_state inside {ST_DETECT, ST_READY};
            power_good_pin_n_o <= !(next_state inside {ST_DETECT,
                                                       ST_READY});
            int_o <= (state == ST_QUALIFY)
                     && (next_state == ST_DETECT); // RQ13
        end
    end

    // Detection result; a detection write wins over a host write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_status_field_o <= `SEQ_STAT_RST;
            input_limit_field_o   <= `SEQ_LIM_RST;
        end else if (state == ST_DETECT) begin
            if (source_select_i) begin
                source_status_field_o <= `SEQ_STAT_USB; // RQ17
                input_limit_field_o   <= second_limit_pin_i ?
                    `SEQ_LIM_500MA : `SEQ_LIM_100MA; // RQ16 RQ17
            end else begin
                source_status_field_o <= `SEQ_STAT_ADAPTER; // RQ16
                input_limit_field_o   <= `SEQ_LIM_ADAPTER;
            end
        end else if (soft_rst) begin
            source_status_field_o <= `SEQ_STAT_RST; // RQ1
            input_limit_field_o   <= `SEQ_LIM_RST;
        end else if (limit_wr_i) begin
            input_limit_field_o <= limit_wdata_i; // RQ16
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence qual_pass_s;
        state == ST_QUALIFY && next_state == ST_DETECT;
    endsequence

    sequence good_report_s;
        power_good_o && !power_good_pin_n_o && int_o;
    endsequence

    por_clear_a: assert property (soft_rst && !switch_off_wr_i // RQ1
        |=> !switch_off_request_o) else $error("reset left request");
    batt_only_a: assert property (bat_above_depl_i // RQ2
        && !vbus_above_uvlo_i && !off_t.done && !rst_pulse
        |=> battery_switch_on_o && !internal_regulator_en_o)
        else $error("battery-only switch not closed");
    off_delay_a: assert property ($rose(switch_off_request_o) // RQ3
        |-> battery_switch_on_o [*2]) else $error("switch opened early");
    req_clear_a: assert property (switch_off_request_o && vbus_rise // RQ6
        && !switch_off_wr_i |=> !switch_off_request_o)
        else $error("insertion kept request");
    wake_on_a: assert property (wake_on_evt && !switch_off_wr_i // RQ7
        |=> !switch_off_request_o) else $error("wake press ignored");
    rst_open_a: assert property (rst_pulse // RQ8
        |=> !battery_switch_on_o) else $error("switch closed in pulse");
    rst_gate_a: assert property (!system_reset_enable_i // RQ9
        |=> !$rose(rst_pulse)) else $error("reset pulse while disabled");
    internal_regulator_cond_a: assert property (!reg_cond // RQ10 RQ11
        |=> !internal_regulator_en_o && high_impedance_state_o)
        else $error("regulator on without conditions");
    qual_load_a: assert property (buck_enable_o // RQ12
        |-> $past(power_good_o)) else $error("buck before qualify");
    good_int_a: assert property (qual_pass_s // RQ13
        |=> good_report_s ##1 !int_o) else $error("power good report bad");
    retry_a: assert property (state == ST_RETRY && reg_cond // RQ14
        |=> state inside {ST_RETRY, ST_QUALIFY})
        else $error("retry left wrongly");
    usb_lim_a: assert property (state == ST_DETECT // RQ17
        && source_select_i && !second_limit_pin_i
        |=> input_limit_field_o == `SEQ_LIM_100MA
            && source_status_field_o == `SEQ_STAT_USB)
        else $error("usb low limit wrong");
    host_hold_a: assert property (host_high_imp_i // RQ18
        |=> state == ST_IDLE) else $error("left host hold");
endmodule : charger_powerup_switch_sequencer

/* File: hw/interval_timer.sv */
`timescale 1ns/10ps
module interval_timer #(
    parameter logic [31:0] LIMIT = 32'h0000_0001
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    tmr_if.tmr        t
);
    logic [31:0] cnt;

    // Counts while run holds, restarts when run drops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 32'h0;
        end else if (!t.run) begin
            cnt <= 32'h0;
        end else if (cnt != LIMIT) begin
            cnt <= cnt + 32'h1;
        end
    end

    assign t.done = t.run && (cnt == LIMIT);
endmodule : interval_timer

/* File: inc/seq_map.svh */
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Clock rate and conversion of milliseconds to clock cycles
`define SEQ_CLK_HZ        40000000
`define SEQ_MS_TO_CYC(ms) ((ms) * (`SEQ_CLK_HZ / 1000))

// Interval lengths in milliseconds
`define SEQ_SW_OFF_DLY_MS  9000
`define SEQ_WAKE_ON_MS     600
`define SEQ_LONG_PRESS_MS  12500
`define SEQ_SW_RST_MS      250
`define SEQ_REG_DLY_MS     220
`define SEQ_POOR_TEST_MS   30
`define SEQ_RETRY_MS       2000

// Source status field codes
`define SEQ_STAT_RST       2'h0
`define SEQ_STAT_USB       2'h1
`define SEQ_STAT_ADAPTER   2'h2

// Input limit field codes
`define SEQ_LIM_100MA      3'h0
`define SEQ_LIM_500MA      3'h2
`define SEQ_LIM_ADAPTER    3'h7
`define SEQ_LIM_RST        3'h0

`endif

/* File: inc/seq_pkg.sv */
package seq_pkg;

    // Input source qualification states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_QUALIFY = 3'h1,
        ST_RETRY   = 3'h2,
        ST_DETECT  = 3'h3,
        ST_READY   = 3'h4
    } qual_state_type;

endpackage : seq_pkg

/* File: inc/tmr_if.sv */
`timescale 1ns/10ps
interface tmr_if;
    logic run;
    logic done;

    modport ctrl (output run, input done);
    modport tmr  (input run, output done);
endinterface : tmr_if

/* File: tb/charger_powerup_switch_sequencer_tb.sv */
`timescale 1ns/10ps
`include "seq_map.svh"
module charger_powerup_switch_sequencer_tb;
    localparam int SW_OFF = 12;
    localparam int WAKE   = 6;
    localparam int LONGP  = 14;
    localparam int SWRST  = 5;
    localparam int REGD   = 8;
    localparam int POOR   = 4;
    localparam int RETRY  = 10;
    typedef struct packed {
        logic       usb;
        logic       fast;
        logic [1:0] stat;
        logic [2:0] lim;
    } row_type;
    localparam row_type ROWS [3] = '{
        '{1'b1, 1'b0, `SEQ_STAT_USB, `SEQ_LIM_100MA},
        '{1'b1, 1'b1, `SEQ_STAT_USB, `SEQ_LIM_500MA},
        '{1'b0, 1'b1, `SEQ_STAT_ADAPTER, `SEQ_LIM_ADAPTER}};
    logic       clk_i, arst_n_i, bat_uvlo, bat_depl, wake_n, sw_wr, sw_data;
    logic       wdog, reg_rst, sys_rst_en, host_hold, lim_wr;
    logic [2:0] lim_data, lim;
    logic       plug, usb, fast, sound, surge, low;
    logic       vbus_ok, sleep_ok, sel, second, above_poor, ovp;
    logic       sw_on, reg_en, highz, load, buck, pgood, pgood_n, irq, req;
    logic [1:0] stat;
    int         fails, checks_done, k, n;

    charger_powerup_switch_sequencer #(
        .SW_OFF_DLY_CYC(32'(SW_OFF)), .WAKE_ON_CYC(32'(WAKE)),
        .LONG_PRESS_CYC(32'(LONGP)), .SW_RST_CYC(32'(SWRST)),
        .REG_DLY_CYC(32'(REGD)), .POOR_TEST_CYC(32'(POOR)),
        .RETRY_CYC(32'(RETRY))
    ) i_charger_powerup_switch_sequencer (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .vbus_above_uvlo_i(vbus_ok),
        .bat_above_uvlo_i(bat_uvlo), .bat_above_depl_i(bat_depl),
        .sleep_ok_i(sleep_ok), .input_ovp_i(ovp),
        .input_above_poor_i(above_poor), .wake_pin_n_i(wake_n),
        .source_select_i(sel), .second_limit_pin_i(second),
        .switch_off_wr_i(sw_wr), .switch_off_wdata_i(sw_data),
        .watchdog_expired_i(wdog), .register_reset_i(reg_rst),
        .system_reset_enable_i(sys_rst_en), .host_high_imp_i(host_hold),
        .limit_wr_i(lim_wr), .limit_wdata_i(lim_data),
        .battery_switch_on_o(sw_on), .internal_regulator_en_o(reg_en),
        .high_impedance_state_o(highz), .poor_test_load_o(load),
        .buck_enable_o(buck), .power_good_o(pgood),
        .power_good_pin_n_o(pgood_n), .int_o(irq),
        .switch_off_request_o(req), .source_status_field_o(stat),
        .input_limit_field_o(lim));

    source_model i_source_model (
        .plug_i(plug), .usb_i(usb), .fast_i(fast), .sound_i(sound),
        .surge_i(surge), .low_i(low), .vbus_ok_o(vbus_ok),
        .sleep_ok_o(sleep_ok),
        .select_o(sel), .second_o(second), .above_poor_o(above_poor),
        .ovp_o(ovp));

    // Clock at 40 MHz
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task chk(input string what, input logic [7:0] seen,
             input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h",
                     what, exp, seen);
        end
    endtask : chk

    task tick(input int c);
        repeat (c) @(negedge clk_i);
    endtask : tick

    function automatic logic pick(input int w);
        return (w == 0) ? irq : (w == 1) ? load : sw_on;
    endfunction : pick

    // Bounded wait for a level on one of the watched outputs
    task wait_for(input int w, input logic v, input int lim_c);
        n = 0;
        while (pick(w) !== v && n < lim_c) begin
            tick(1);
            n++;
        end
        chk("wait", 8'(n < lim_c), 8'h01);
    endtask : wait_for

    task host_wr(input logic d);
        @(posedge clk_i);
        sw_wr   <= 1'b1;
        sw_data <= d;
        @(posedge clk_i);
        sw_wr   <= 1'b0;
    endtask : host_wr

    task wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Hang guard, well past the length of all tests
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        wrap_up();
    end

    // Main sequence
    initial begin
        fails = 0;
        checks_done = 0;
        arst_n_i = 1'b0;
        bat_uvlo = 1'b1;
        bat_depl = 1'b1;
        wake_n = 1'b1;
        sw_wr = 1'b0;
        sw_data = 1'b0;
        wdog = 1'b0;
        reg_rst = 1'b0;
        sys_rst_en = 1'b0;
        host_hold = 1'b0;
        lim_wr = 1'b0;
        lim_data = 3'h0;
        plug = 1'b0;
        usb = 1'b0;
        fast = 1'b0;
        sound = 1'b1;
        surge = 1'b0;
        low = 1'b0;
        tick(1);
        chk("highz", 8'(highz), 8'h01);
        chk("pgood_n", 8'(pgood_n), 8'h01);
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(2);
        chk("sw_on", 8'(sw_on), 8'h01);
        chk("reg_en", 8'(reg_en), 8'h00);
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            @(posedge clk_i);
            usb  <= ROWS[k].usb;
            fast <= ROWS[k].fast;
            plug <= 1'b1;
            tick(REGD);
            chk("reg_en", 8'(reg_en), 8'h00);
            wait_for(0, 1'b1, REGD + POOR + 20);
            chk("pgood", 8'(pgood), 8'h01);
            chk("pgood_n", 8'(pgood_n), 8'h00);
            tick(1);
            chk("irq", 8'(irq), 8'h00);
            chk("stat", 8'(stat), 8'(ROWS[k].stat));
            chk("lim", 8'(lim), 8'(ROWS[k].lim));
            tick(1);
            chk("buck", 8'(buck), 8'h01);
            @(posedge clk_i);
            plug <= 1'b0;
            tick(2);
            chk("off", 8'({highz, reg_en, pgood_n}), 8'h05);
            $display("test source row %0d done", k);
        end
        @(posedge clk_i);
        bat_uvlo <= 1'b0;
        @(posedge clk_i);
        bat_uvlo <= 1'b1;
        tick(2);
        chk("fields", 8'({stat, lim}), 8'h00);
        @(posedge clk_i);
        usb   <= 1'b0;
        sound <= 1'b0;
        plug  <= 1'b1;
        wait_for(1, 1'b1, REGD + 20);
        wait_for(1, 1'b0, POOR + 4);
        wait_for(1, 1'b1, RETRY + 10);
        chk("gap", 8'(n >= RETRY && n <= RETRY + 4), 8'h01);
        chk("pgood", 8'(pgood), 8'h00);
        @(posedge clk_i);
        sound <= 1'b1;
        surge <= 1'b1;
        tick(RETRY + POOR + 6);
        chk("pgood", 8'(pgood), 8'h00);
        @(posedge clk_i);
        surge <= 1'b0;
        wait_for(0, 1'b1, RETRY + POOR + 10);
        @(posedge clk_i);
        plug <= 1'b0;
        $display("test poor source done");
        @(posedge clk_i);
        low  <= 1'b1;
        plug <= 1'b1;
        tick(REGD + 4);
        chk("sleep", 8'({highz, reg_en}), 8'h02);
        @(posedge clk_i);
        low       <= 1'b0;
        host_hold <= 1'b1;
        tick(REGD + POOR + 20);
        chk("held", 8'({highz, reg_en, pgood}), 8'h04);
        @(posedge clk_i);
        reg_rst <= 1'b1;
        @(posedge clk_i);
        reg_rst   <= 1'b0;
        host_hold <= 1'b0;
        tick(1);
        chk("fields", 8'({stat, lim}), 8'h00);
        wait_for(0, 1'b1, REGD + POOR + 20);
        tick(1);
        chk("stat", 8'(stat), 8'(`SEQ_STAT_ADAPTER));
        @(posedge clk_i);
        lim_wr   <= 1'b1;
        lim_data <= 3'h5;
        @(posedge clk_i);
        lim_wr   <= 1'b0;
        plug     <= 1'b0;
        tick(1);
        chk("lim", 8'(lim), 8'h05);
        $display("test host control done");
        for (k = 0; k < 5; k++) begin
            host_wr(1'b1);
            tick(1);
            chk("req", 8'(req), 8'h01);
            tick(SW_OFF - 2);
            chk("sw_on", 8'(sw_on), 8'h01);
            tick(5);
            chk("sw_on", 8'(sw_on), 8'h00);
            @(posedge clk_i);
            case (k)
                0: sw_data <= 1'b0;
                1: wdog    <= 1'b1;
                2: reg_rst <= 1'b1;
                3: plug    <= 1'b1;
                default: wake_n <= 1'b0;
            endcase
            sw_wr <= (k == 0);
            repeat ((k == 4) ? WAKE + 4 : 1) @(posedge clk_i);
            sw_wr   <= 1'b0;
            wdog    <= 1'b0;
            reg_rst <= 1'b0;
            wake_n  <= 1'b1;
            tick(4);
            chk("req", 8'(req), 8'h00);
            chk("sw_on", 8'(sw_on), 8'h01);
            @(posedge clk_i);
            plug <= 1'b0;
            tick(2);
        end
        $display("test switch off done");
        @(posedge clk_i);
        sys_rst_en <= 1'b1;
        wake_n     <= 1'b0;
        tick(LONGP - 2);
        chk("sw_on", 8'(sw_on), 8'h01);
        wait_for(2, 1'b0, 20);
        wait_for(2, 1'b1, SWRST + 8);
        chk("pulse", 8'(n), 8'(SWRST + 1));
        @(posedge clk_i);
        wake_n     <= 1'b1;
        sys_rst_en <= 1'b0;
        tick(2);
        @(posedge clk_i);
        wake_n <= 1'b0;
        n = 0;
        repeat (LONGP + 10) begin
            tick(1);
            n += (sw_on !== 1'b1);
        end
        chk("drops", 8'(n), 8'h00);
        $display("test long press done");
        host_wr(1'b1);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        tick(1);
        chk("rst", 8'({sw_on, req, highz, pgood_n}), 8'h03);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(2);
        chk("sw_on", 8'(sw_on), 8'h01);
        $display("test mid reset done");
        wrap_up();
    end
endmodule : charger_powerup_switch_sequencer_tb

/* File: tb/source_model.sv */
`timescale 1ns/10ps
// Input source as seen at the input pins: adapter or usb port
module source_model (
    input  wire logic plug_i,
    input  wire logic usb_i,
    input  wire logic fast_i,
    input  wire logic sound_i,
    input  wire logic surge_i,
    input  wire logic low_i,
    output logic      vbus_ok_o,
    output logic      sleep_ok_o,
    output logic      select_o,
    output logic      second_o,
    output logic      above_poor_o,
    output logic      ovp_o
);
    // Supply levels collapse to zero once the source is pulled out
    assign vbus_ok_o    = plug_i;
    // Input below battery plus sleep margin while low_i is high
    assign sleep_ok_o   = plug_i & ~low_i;
    assign above_poor_o = plug_i & sound_i;
    assign ovp_o        = plug_i & surge_i;
    // Phy keeps both select lines driven while the system runs
    assign select_o     = usb_i;
    assign second_o     = fast_i;
endmodule : source_model
